/* hw/epsi_irq_logic.sv */
// Request flags and vector request for the error, phase, serial, converter
// and eight shared-group interrupts, with an AXI4-Lite register slave.
// Assumes event inputs are one-cycle pulses or levels from logic on ref_clk_in.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "epsi_consts.svh"

module epsi_irq_logic #(
  parameter int NUM_GRP = 8,
  parameter int NUM_OVP = 7
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Error sources
  input wire logic phase_protect_output_in,
  input wire logic [NUM_OVP-1:0] overvoltage_comparator_outputs_in,
  // Phase detectors: short or zero width seen
  input wire logic [1:0] phase_width_fault_in,
  // Serial module
  input wire logic [1:0] serial_mode_in,
  input wire epsi_pkg::epsi_serial_ev_t serial_events_in,
  // Converter
  input wire logic conv_manual_done_in,
  input wire logic conv_group_done_in,
  // Grouped source flags, ORed per group by their owners
  input wire logic [NUM_GRP-1:0] shared_group_sources_in,
  // Sequencer side
  input wire logic stack_full_in,
  input wire logic vector_ack_in,
  output epsi_pkg::epsi_vec_req_t vec_req_out,
  output logic wake_out,
  // AXI4-Lite
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NREQ = `EPSI_NUM_REQ;

  epsi_pkg::epsi_state_t st_ff;
  epsi_pkg::epsi_state_t nxt_st;

  // Byte-lane merge, used by the error-config and enable registers
  function automatic logic [31:0] epsi_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : epsi_merge

  // Lowest set index wins, a fixed order
  function automatic logic [3:0] epsi_pick(input logic [NREQ-1:0] req);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NREQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : epsi_pick

  // Raw events for each request flag
  logic [NREQ-1:0] set_ev;
  logic [8:0] err_trig;
  logic sync_ev;
  logic async_ev;
  logic sw_rise;
  logic [NREQ-1:0] servable;
  logic [NREQ-1:0] sw_clear;
  logic [NREQ-1:0] hw_clear;
  logic wr_fire;
  logic [31:0] wr_merged;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // Software rising edge seen at the write that raises it
  assign sw_rise = wr_fire && (st_ff.aw_addr == `EPSI_OFS_CTRL) && st_ff.w_strb[0] &&
                   st_ff.w_data[`EPSI_CTRL_SWTRIG] && !st_ff.sw_trig;

  // Nine sources gated by nine enables; the software bit needs its own lane
  assign err_trig = {sw_rise, overvoltage_comparator_outputs_in,
                     phase_protect_output_in} & st_ff.err_src_en;

  // Serial event sets depend on mode family
  assign sync_ev = serial_events_in.byte_done | serial_events_in.addr_match |
                   serial_events_in.bus_timeout;
  assign async_ev = serial_events_in.tx_empty | serial_events_in.tx_idle |
                    serial_events_in.rx_avail | serial_events_in.rx_overrun |
                    serial_events_in.addr_detect | serial_events_in.rx_wake;

  // Per-flag set events
  always_comb begin
    set_ev = '0;
    set_ev[`EPSI_BIT_ERR] = |err_trig;
    set_ev[`EPSI_BIT_PHASE] = |phase_width_fault_in;
    set_ev[`EPSI_BIT_SERIAL] = (serial_mode_in == `EPSI_MODE_ASYNC) ? async_ev :
                               (((serial_mode_in == `EPSI_MODE_SYNC) ||
                                 (serial_mode_in == `EPSI_MODE_TWI)) ? sync_ev : 1'b0);
    set_ev[`EPSI_BIT_CONV] = conv_manual_done_in | conv_group_done_in;
    // Group flag sets when its group's ORed source input rises
    set_ev[`EPSI_BIT_GRP0 +: NUM_GRP] = shared_group_sources_in &
                                        ~st_ff.grp_src_prev;
  end

  // Requests allowed to reach the sequencer
  assign servable = st_ff.req_flag & st_ff.irq_en;

  // Vector request held until the sequencer acknowledges
  always_comb begin
    vec_req_out.valid = st_ff.gie && !stack_full_in && (|servable);
    vec_req_out.vector = epsi_pick(servable);
  end

  // Service clears only the chosen flag; sources outside stay set
  always_comb begin
    hw_clear = '0;
    if (vec_req_out.valid && vector_ack_in) begin
      hw_clear[epsi_pick(servable)] = 1'b1;
    end
  end

  // Any latched flag wakes the core, enabled or not
  assign wake_out = |st_ff.req_flag;

  // AXI write fires once address and data are both held
  assign wr_fire = st_ff.wr_addr_done && st_ff.wr_data_done && !st_ff.bvalid;
  assign wr_hit = (st_ff.aw_addr == `EPSI_OFS_CTRL) || (st_ff.aw_addr == `EPSI_OFS_ERRCFG) ||
                  (st_ff.aw_addr == `EPSI_OFS_ENABLE) || (st_ff.aw_addr == `EPSI_OFS_CLEAR);
  assign wr_merged = st_ff.w_data;

  // Write-one-to-clear of request flags by software
  assign sw_clear = (wr_fire && st_ff.aw_addr == `EPSI_OFS_CLEAR) ?
                    st_ff.w_data[NREQ-1:0] : '0;

  // Read decode
  always_comb begin
    rd_hit = 1'b1;
    rd_word = `EPSI_RST_WORD;
    case (s_axi_araddr)
      `EPSI_OFS_CTRL: begin
        rd_word[`EPSI_CTRL_GIE] = st_ff.gie;
        rd_word[`EPSI_CTRL_SWTRIG] = st_ff.sw_trig;
      end
      `EPSI_OFS_ERRCFG: rd_word[8:0] = st_ff.err_src_en;
      `EPSI_OFS_ENABLE: rd_word[NREQ-1:0] = st_ff.irq_en;
      `EPSI_OFS_FLAGS: rd_word[NREQ-1:0] = st_ff.req_flag;
      `EPSI_OFS_CLEAR: rd_word = `EPSI_RST_WORD;
      `EPSI_OFS_STATUS: begin
        rd_word[NREQ-1:0] = servable;
        rd_word[16] = vec_req_out.valid;
        rd_word[23:20] = vec_req_out.vector;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Handshake outputs
  assign s_axi_awready = !st_ff.wr_addr_done && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.wr_data_done && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.grp_src_prev = shared_group_sources_in;
    // Set wins over either clear so no event is lost
    nxt_st.req_flag = (st_ff.req_flag & ~hw_clear & ~sw_clear) | set_ev;
    // Every service also clears the global enable; serial service never touches async status
    if (vec_req_out.valid && vector_ack_in) begin
      nxt_st.gie = 1'b0;
    end
    // Write address and data, either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.wr_addr_done = 1'b1;
      nxt_st.aw_addr = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.wr_data_done = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_st.wr_addr_done = 1'b0;
      nxt_st.wr_data_done = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wr_hit ? `EPSI_RESP_OKAY : `EPSI_RESP_SLVERR;
      case (st_ff.aw_addr)
        `EPSI_OFS_CTRL: begin
          if (st_ff.w_strb[0]) begin
            // A write of one re-enables nesting even while serving
            nxt_st.gie = st_ff.w_data[`EPSI_CTRL_GIE];
            nxt_st.sw_trig = st_ff.w_data[`EPSI_CTRL_SWTRIG];
          end
        end
        `EPSI_OFS_ERRCFG: begin
          nxt_st.err_src_en = 9'(epsi_merge({23'h00_0000, st_ff.err_src_en}, wr_merged,
                                            st_ff.w_strb));
        end
        `EPSI_OFS_ENABLE: begin
          nxt_st.irq_en = 12'(epsi_merge({20'h0_0000, st_ff.irq_en}, wr_merged,
                                         st_ff.w_strb));
        end
        default: begin
        end
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // Read answer registered one cycle after address
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_word;
      nxt_st.rresp = rd_hit ? `EPSI_RESP_OKAY : `EPSI_RESP_SLVERR;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : epsi_irq_logic

/* inc/epsi_consts.svh */
// Constants for the error, phase, serial, converter and shared-group interrupt logic.
// Assumes a single 100 MHz clock and AXI4-Lite register access with 32-bit data.
// Notes on behaviour
// - Error interrupt merges phase output, seven overvoltage outputs and a software bit.
// - Software trigger fires only on its rising edge, never on level.
// - Error flag sets only when a source fires with its enable high.
// - Error vector requested only with global and own enable, stack free.
// - Serving error vector clears its flag and the global enable.
// - Phase flag sets when either detector sees zero or short width.
// - Phase vector needs both enables and free stack; service clears flag, global.
// - Sync or two-wire mode: byte done, address match, time-out set serial flag.
// - Async mode: tx empty, idle, rx data, overrun, address, wake set flag.
// - Serial service clears its flag and global enable; needs enables, free stack.
// - Serial service leaves async status flags alone; their unit clears them.
// - Converter flag sets at end of manual conversion or auto group.
// - Converter vector needs global and converter enable, free stack, done.
// - Converter service clears converter flag and global enable.
// - Eight shared-group interrupts merge requests of many peripheral sources.
// - Shared-group flag sets whenever any grouped source flag becomes set; the logic sets it only when the group's ORed input rises.
// - Shared-group vector needs its enable, free stack and a grouped source.
// - Shared-group service clears only that group flag and the global enable.
// - With global enable clear, requests are held but not served.
// - Any set request flag wakes the device from sleep or idle.
`ifndef EPSI_CONSTS_SVH
`define EPSI_CONSTS_SVH

// Register byte offsets
`define EPSI_OFS_CTRL 12'h000
`define EPSI_OFS_ERRCFG 12'h004
`define EPSI_OFS_ENABLE 12'h008
`define EPSI_OFS_FLAGS 12'h00c
`define EPSI_OFS_CLEAR 12'h010
`define EPSI_OFS_STATUS 12'h014

// Control register fields
`define EPSI_CTRL_GIE 0
`define EPSI_CTRL_SWTRIG 1

// Flag and enable bit positions (also the priority order, lowest index first)
`define EPSI_BIT_ERR 0
`define EPSI_BIT_PHASE 1
`define EPSI_BIT_SERIAL 2
`define EPSI_BIT_CONV 3
`define EPSI_BIT_GRP0 4
`define EPSI_NUM_REQ 12

// Vector numbers
`define EPSI_VEC_ERR 4'h0
`define EPSI_VEC_PHASE 4'h1
`define EPSI_VEC_SERIAL 4'h2
`define EPSI_VEC_CONV 4'h3

// Serial mode encodings
`define EPSI_MODE_SYNC 2'h0
`define EPSI_MODE_TWI 2'h1
`define EPSI_MODE_ASYNC 2'h2

// Reset values
`define EPSI_RST_WORD 32'h0000_0000

// AXI responses
`define EPSI_RESP_OKAY 2'h0
`define EPSI_RESP_SLVERR 2'h2

`endif

/* inc/epsi_pkg.sv */
// Types for the interrupt request logic.
// Assumes epsi_consts.svh is included by the design file for numbers.
package epsi_pkg;

  // Serial module events, both mode families
  typedef struct packed {
    logic byte_done;
    logic addr_match;
    logic bus_timeout;
    logic tx_empty;
    logic tx_idle;
    logic rx_avail;
    logic rx_overrun;
    logic addr_detect;
    logic rx_wake;
  } epsi_serial_ev_t;

  // Vector request toward the sequencer
  typedef struct packed {
    logic valid;
    logic [3:0] vector;
  } epsi_vec_req_t;

  // Bus slave phase
  typedef enum logic [1:0] {
    EPSI_BUS_IDLE = 2'b00,
    EPSI_BUS_RESP = 2'b01
  } epsi_bus_st_t;

  // Whole state of the block
  typedef struct packed {
    logic gie;
    logic sw_trig;
    logic [8:0] err_src_en; // Phase, seven comparators, software bit
    logic [11:0] irq_en;
    logic [11:0] req_flag;
    logic [7:0] grp_src_prev;
    logic wr_addr_done;
    logic wr_data_done;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } epsi_state_t;

endpackage : epsi_pkg

/* verification/epsi_irq_logic_asserts.sv */
// Port-level checks on the interrupt request logic.
// Assumes one clock domain; bound to the top module from the bench.
`timescale 1ns/100ps
module epsi_irq_logic_asserts #(
  parameter int NUM_GRP = 8
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [1:0] phase_width_fault_in,
  input wire logic [1:0] serial_mode_in,
  input wire epsi_pkg::epsi_serial_ev_t serial_events_in,
  input wire logic conv_manual_done_in,
  input wire logic conv_group_done_in,
  input wire logic [NUM_GRP-1:0] shared_group_sources_in,
  input wire logic stack_full_in,
  input wire logic vector_ack_in,
  input wire epsi_pkg::epsi_vec_req_t vec_req_out,
  input wire logic wake_out,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Service handshake and the two bus hand-offs
  sequence s_take; vec_req_out.valid && vector_ack_in; endsequence
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  property p_full; stack_full_in |-> !vec_req_out.valid; endproperty
  property p_serve; s_take |=> !vec_req_out.valid; endproperty
  property p_phase; phase_width_fault_in != 2'h0 |=> wake_out; endproperty
  property p_conv; conv_manual_done_in || conv_group_done_in |=> wake_out; endproperty
  property p_sync; serial_mode_in < 2'h2 && serial_events_in[8:6] != 3'h0 |=> wake_out;
  endproperty
  property p_async; serial_mode_in == 2'h2 && serial_events_in[5:0] != 6'h0 |=> wake_out;
  endproperty
  property p_grp; (shared_group_sources_in & ~$past(shared_group_sources_in)) != 0 |=> wake_out;
  endproperty
  property p_idle; !wake_out |-> !vec_req_out.valid; endproperty
  property p_bresp; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
  property p_rresp; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
  a_full: assert property (p_full) else $error("request while stack full");
  a_serve: assert property (p_serve) else $error("request held after service");
  a_phase: assert property (p_phase) else $error("phase fault not latched");
  a_conv: assert property (p_conv) else $error("conversion end not latched");
  a_sync: assert property (p_sync) else $error("sync serial event lost");
  a_async: assert property (p_async) else $error("async serial event lost");
  a_grp: assert property (p_grp) else $error("group source edge lost");
  a_idle: assert property (p_idle) else $error("request without any flag");
  a_bresp: assert property (p_bresp) else $error("write response late");
  a_rresp: assert property (p_rresp) else $error("read response late");
endmodule : epsi_irq_logic_asserts

/* verification/epsi_seq_model.sv */
// Sequencer stand-in: takes vector requests and pulses acknowledge.
// Assumes requests are combinational and stand until acknowledged.
`timescale 1ns/100ps
module epsi_seq_model (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire epsi_pkg::epsi_vec_req_t req_in,
  input wire logic full_cmd_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic stack_full_out,
  output logic [3:0] seen_vec_out,
  output logic [7:0] seen_cnt_out
);
  logic [1:0] wait_ff;
  // Stack fill level is commanded by the bench
  assign stack_full_out = full_cmd_in;
  // Ack one cycle after seeing a request, or four when slow, so holding is exercised
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_out <= 1'b0;
      wait_ff <= 2'h0;
      seen_vec_out <= 4'h0;
      seen_cnt_out <= 8'h00;
    end else begin
      ack_out <= 1'b0;
      if (req_in.valid && !ack_out) begin
        if (!slow_in || wait_ff == 2'h3) begin
          ack_out <= 1'b1;
          seen_vec_out <= req_in.vector;
          seen_cnt_out <= seen_cnt_out + 8'h01;
          wait_ff <= 2'h0;
        end else begin
          wait_ff <= wait_ff + 2'h1;
        end
      end
    end
  end
endmodule : epsi_seq_model

/* verification/tb_epsi_irq_logic.sv */
// Self-checking bench for the interrupt request logic.
// Assumes the sequencer model in epsi_seq_model.sv and the bound checker.
`timescale 1ns/100ps
`include "epsi_consts.svh"
module tb_epsi_irq_logic;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [30:0] stim = 31'h0;
  logic [1:0] mode;
  epsi_pkg::epsi_serial_ev_t sev;
  logic ph, cm, cg;
  logic [6:0] ovp;
  logic [1:0] pwf;
  logic [7:0] grp;
  logic full_cmd = 1'b0, slow = 1'b0, ack, sfull;
  epsi_pkg::epsi_vec_req_t vreq;
  logic wake, awr, wr_rdy, bv, arr, rv;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rd_d, rdat;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [1:0] bresp, rresp, rd_r;
  logic [3:0] seen_vec;
  logic [7:0] seen_cnt, c0;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  logic [34:0] rows [15] = '{{31'h0008_0000, 4'h0}, {31'h0004_0000, 4'h0},
    {31'h0000_0800, 4'h1}, {31'h0000_0400, 4'h1}, {31'h1000_0000, 4'h2},
    {31'h2800_0000, 4'h2}, {31'h2400_0000, 4'h2}, {31'h4200_0000, 4'h2},
    {31'h4100_0000, 4'h2}, {31'h4080_0000, 4'h2}, {31'h4040_0000, 4'h2},
    {31'h4020_0000, 4'h2}, {31'h4010_0000, 4'h2}, {31'h0000_0200, 4'h3},
    {31'h0000_0100, 4'h3}};
  assign {mode, sev, ph, ovp, pwf, cm, cg, grp} = stim;
  epsi_irq_logic i_epsi_irq_logic (.ref_clk_in, .reset_n_in, .phase_protect_output_in(ph),
    .overvoltage_comparator_outputs_in(ovp), .phase_width_fault_in(pwf), .serial_mode_in(mode),
    .serial_events_in(sev), .conv_manual_done_in(cm), .conv_group_done_in(cg),
    .shared_group_sources_in(grp), .stack_full_in(sfull), .vector_ack_in(ack),
    .vec_req_out(vreq), .wake_out(wake), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry));
  epsi_seq_model i_epsi_seq_model (.ref_clk_in, .reset_n_in, .req_in(vreq),
    .full_cmd_in(full_cmd), .slow_in(slow), .ack_out(ack), .stack_full_out(sfull),
    .seen_vec_out(seen_vec), .seen_cnt_out(seen_cnt));
  // Free-running clock and hang guard
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Bus master: each channel released only at its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    forever begin
      @(posedge ref_clk_in);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (bv) break;
    end
    bry <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk_in);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    forever begin
      @(posedge ref_clk_in);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rd_d = rdat; rd_r = rresp;
    rry <= 1'b0;
  endtask : rd
  // Set global enable, pulse an event, expect the given vector to be taken
  task automatic take(input logic [30:0] s, input logic [3:0] v);
    int n;
    n = 0;
    c0 = seen_cnt;
    wr(`EPSI_OFS_CTRL, 32'h1);
    @(posedge ref_clk_in) stim <= s;
    @(posedge ref_clk_in) stim <= 31'h0;
    while (seen_cnt == c0 && n < 60) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk("vector", {28'h0, seen_vec}, {28'h0, v});
    chk("taken", {24'h0, seen_cnt}, {24'h0, c0 + 8'h01});
  endtask : take
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (16) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(posedge ref_clk_in);
    chk("wake", {31'h0, wake}, 32'h0);
    rd(`EPSI_OFS_ENABLE);
    chk("enable", rd_d, 32'h0);
    wr(`EPSI_OFS_ENABLE, 32'hfff);
    wr(`EPSI_OFS_ERRCFG, 32'h1ff);
    // Every source kind to its own vector; flag gone after service
    foreach (rows[i]) begin
      take(rows[i][34:4], rows[i][3:0]);
      rd(`EPSI_OFS_FLAGS);
      chk("flags", rd_d, 32'h0);
    end
    slow <= 1'b1;
    for (int k = 0; k < 8; k++) take(31'h1 << k, 4'h4 + 4'(k));
    slow <= 1'b0;
    // Held while global enable is off, blocked by full stack, then by priority
    wr(`EPSI_OFS_CTRL, 32'h0);
    @(posedge ref_clk_in) stim <= 31'h0000_0680;
    @(posedge ref_clk_in) stim <= 31'h0;
    rd(`EPSI_OFS_FLAGS);
    chk("held", rd_d, 32'h80a);
    chk("novec", {31'h0, vreq.valid}, 32'h0);
    chk("wake", {31'h0, wake}, 32'h1);
    full_cmd <= 1'b1;
    c0 = seen_cnt;
    wr(`EPSI_OFS_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk_in);
    chk("full", {24'h0, seen_cnt}, {24'h0, c0});
    // Free the stack with global enable off, so each take serves one flag
    wr(`EPSI_OFS_CTRL, 32'h0);
    full_cmd <= 1'b0;
    take(31'h0, 4'h1);
    take(31'h0, 4'h3);
    take(31'h0, 4'hb);
    // Disabled error source leaves the flag alone
    wr(`EPSI_OFS_ERRCFG, 32'h0);
    // Serial mode 3 with every event also leaves the serial flag clear
    @(posedge ref_clk_in) stim <= 31'h7ff4_0000;
    @(posedge ref_clk_in) stim <= 31'h0;
    rd(`EPSI_OFS_FLAGS);
    chk("masked", rd_d, 32'h0);
    // Software trigger fires on a rising write only, never on a held one
    wr(`EPSI_OFS_ERRCFG, 32'h100);
    wr(`EPSI_OFS_CTRL, 32'h2);
    rd(`EPSI_OFS_FLAGS);
    chk("swtrig", rd_d, 32'h1);
    wr(`EPSI_OFS_CLEAR, 32'h1);
    wr(`EPSI_OFS_CTRL, 32'h2);
    rd(`EPSI_OFS_FLAGS);
    chk("swlevel", rd_d, 32'h0);
    rd(12'hffc);
    chk("unmapped", {rd_r, rd_d[29:0]}, {2'h2, 30'h0});
    wrap_up();
  end
endmodule : tb_epsi_irq_logic
bind epsi_irq_logic epsi_irq_logic_asserts #(.NUM_GRP(NUM_GRP)) i_chk (.ref_clk_in,
  .reset_n_in, .phase_width_fault_in, .serial_mode_in, .serial_events_in,
  .conv_manual_done_in, .conv_group_done_in, .shared_group_sources_in, .stack_full_in,
  .vector_ack_in, .vec_req_out, .wake_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
